//--- tpip_ctl.sv
`timescale 1ns/10ps
module tpip_ctl #(
   parameter int unsigned NSUB = tpip_pkg::NSUB,
   parameter int unsigned NPIN = tpip_pkg::NPIN
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [tpip_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [tpip_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [tpip_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [2*NSUB-1:0] sub_mode,
   input wire logic [NPIN-1:0] cnt_run,
   input wire logic [NPIN-1:0] cnt_wrap,
   input wire logic [NPIN-1:0] duty_match,
   input wire logic [NPIN-1:0] period_match,
   input wire logic [NSUB-1:0] cnt_overflow,
   input wire logic [NPIN-1:0] timer_pin_in,
   output logic [NPIN-1:0] timer_pin_out,
   output logic [NPIN-1:0] timer_pin_oe,
   output logic [NSUB-1:0] prescale_tick,
   output logic [NSUB-1:0] capture_to_period,
   output logic [NSUB-1:0] capture_to_duty,
   output logic [NSUB-1:0] counter_reset,
   output logic [NSUB-1:0] irq_req,
   output logic irq
);
   localparam int unsigned DW = tpip_pkg::DATA_W;
   localparam int unsigned PW = tpip_pkg::PRE_W;
   localparam int unsigned FW = tpip_pkg::PIN_FLD_W;
   localparam int unsigned PPS = tpip_pkg::PEND_PER_SUB;
   // local alias keeps the mode casts short without importing the package
   typedef tpip_pkg::tpip_mode_t tpip_mode_t;

   // ****************************************
   // registers
   // ****************************************
   logic [DW-1:0] pin_control_low_reg, pin_control_low_next;
   logic [DW-1:0] pin_control_high_reg, pin_control_high_next;
   logic [DW-1:0] irq_enable_reg, irq_enable_next;
   logic [DW-1:0] irq_pending_reg, irq_pending_next;
   logic [DW-1:0] prescale_pair_a_reg, prescale_pair_a_next;
   logic [DW-1:0] prescale_pair_b_reg, prescale_pair_b_next;
   logic [DW-1:0] rdata_reg, rdata_next;
   logic [DW-1:0] pend_set;
   logic [2*DW-1:0] pin_ctl_all;
   logic [2*DW-1:0] pre_all;
   logic [1:0] mode_f [NSUB];

   // flat views: pin i owns nibble i, subsystem s owns byte s
   assign pin_ctl_all = {pin_control_high_reg, pin_control_low_reg};
   assign pre_all = {prescale_pair_b_reg, prescale_pair_a_reg};

   always_comb begin
      for (int s = 0; s < NSUB; s++) begin
         mode_f[s] = sub_mode[2*s +: 2];
      end
   end

   // register file: writes land at the edge that samples the strobe
   always_comb begin
      pin_control_low_next = pin_control_low_reg;
      pin_control_high_next = pin_control_high_reg;
      irq_enable_next = irq_enable_reg;
      prescale_pair_a_next = prescale_pair_a_reg;
      prescale_pair_b_next = prescale_pair_b_reg;
      irq_pending_next = irq_pending_reg;
      rdata_next = tpip_pkg::RST_ZERO;

      if (reg_wr) begin
         unique case (reg_addr)
            tpip_pkg::OFF_PIN_LOW: pin_control_low_next = reg_wdata;
            tpip_pkg::OFF_PIN_HIGH: pin_control_high_next = reg_wdata;
            tpip_pkg::OFF_IRQ_EN: irq_enable_next = reg_wdata;
            tpip_pkg::OFF_PRE_A: prescale_pair_a_next = reg_wdata;
            tpip_pkg::OFF_PRE_B: prescale_pair_b_next = reg_wdata;
            default: ;
         endcase
      end

      // write-one clears, but not for a subsystem in low-power mode
      if (reg_wr && reg_addr == tpip_pkg::OFF_IRQ_PEND) begin
         for (int s = 0; s < NSUB; s++) begin
            if (tpip_mode_t'(mode_f[s]) != tpip_pkg::TPIP_LOWPWR) begin
               irq_pending_next[PPS*s +: PPS] =
                  irq_pending_reg[PPS*s +: PPS] & ~reg_wdata[PPS*s +: PPS];
            end
         end
      end

      // an event in the clearing cycle survives: set wins
      irq_pending_next = irq_pending_next | pend_set;

      // unmapped reads answer zero, as does every cycle without a read
      if (reg_rd) begin
         unique case (reg_addr)
            tpip_pkg::OFF_PIN_LOW: rdata_next = pin_control_low_reg;
            tpip_pkg::OFF_PIN_HIGH: rdata_next = pin_control_high_reg;
            tpip_pkg::OFF_IRQ_EN: rdata_next = irq_enable_reg;
            tpip_pkg::OFF_IRQ_PEND: rdata_next = irq_pending_reg;
            tpip_pkg::OFF_PRE_A: rdata_next = prescale_pair_a_reg;
            tpip_pkg::OFF_PRE_B: rdata_next = prescale_pair_b_reg;
            default: rdata_next = tpip_pkg::RST_ZERO;
         endcase
      end
   end


   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pin_control_low_reg <= tpip_pkg::RST_ZERO;
         pin_control_high_reg <= tpip_pkg::RST_ZERO;
         irq_enable_reg <= tpip_pkg::RST_ZERO;
         irq_pending_reg <= tpip_pkg::RST_ZERO;
         prescale_pair_a_reg <= tpip_pkg::RST_ZERO;
         prescale_pair_b_reg <= tpip_pkg::RST_ZERO;
         rdata_reg <= tpip_pkg::RST_ZERO;
      end else begin
         pin_control_low_reg <= pin_control_low_next;
         pin_control_high_reg <= pin_control_high_next;
         irq_enable_reg <= irq_enable_next;
         irq_pending_reg <= irq_pending_next;
         prescale_pair_a_reg <= prescale_pair_a_next;
         prescale_pair_b_reg <= prescale_pair_b_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ****************************************
   // pin synchronisers and edge detect
   // ****************************************
   logic [NPIN-1:0] sync1_reg, sync2_reg, prev_reg;
   logic [NPIN-1:0] rise, fall;

   // prev_reg is the edge memory; only sync2_reg reads the first stage
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg <= '0;
      end else begin
         sync1_reg <= timer_pin_in;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   assign rise = sync2_reg & ~prev_reg;
   assign fall = ~sync2_reg & prev_reg;

   // ****************************************
   // capture decode
   // ****************************************
   // returns {capture, counter reset} for one pin
   // codes 5 and 6 capture on both edges but reset on the chosen edge only; code 7 resets on both
   function automatic logic [1:0] edge_decode(input logic [2:0] sel, input logic r,
                                              input logic f);
      logic [1:0] res;
      res = 2'h0;
      unique case (sel)
         tpip_pkg::EDG_RISE: res = {r, 1'b0};
         tpip_pkg::EDG_FALL: res = {f, 1'b0};
         tpip_pkg::EDG_RISE_RST: res = {r, r};
         tpip_pkg::EDG_FALL_RST: res = {f, f};
         tpip_pkg::EDG_BOTH: res = {r | f, 1'b0};
         tpip_pkg::EDG_BOTH_RRST: res = {r | f, r};
         tpip_pkg::EDG_BOTH_FRST: res = {r | f, f};
         tpip_pkg::EDG_BOTH_BRST: res = {r | f, r | f};
      endcase

      return res;
   endfunction

   logic [NSUB-1:0] cap_per_next, cap_dty_next, crst_next;
   logic [NSUB-1:0] cap_per_reg, cap_dty_reg, crst_reg;
   logic [1:0] dec_lo, dec_hi;

   always_comb begin
      cap_per_next = '0;
      cap_dty_next = '0;
      crst_next = '0;
      dec_lo = 2'h0;
      dec_hi = 2'h0;

      for (int s = 0; s < NSUB; s++) begin
         dec_lo = edge_decode(pin_ctl_all[FW*(2*s) + tpip_pkg::EDGE_LSB +: tpip_pkg::EDGE_W],
                              rise[2*s], fall[2*s]);
         dec_hi = edge_decode(pin_ctl_all[FW*(2*s+1) + tpip_pkg::EDGE_LSB +: tpip_pkg::EDGE_W],
                              rise[2*s+1], fall[2*s+1]);

         // edges only count in capture mode with the counter running
         if (tpip_mode_t'(mode_f[s]) == tpip_pkg::TPIP_CAPT && cnt_run[2*s]) begin
            cap_per_next[s] = dec_lo[1];
            cap_dty_next[s] = dec_hi[1];
            crst_next[s] = dec_lo[0] | dec_hi[0];
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cap_per_reg <= '0;
         cap_dty_reg <= '0;
         crst_reg <= '0;
      end else begin
         cap_per_reg <= cap_per_next;
         cap_dty_reg <= cap_dty_next;
         crst_reg <= crst_next;
      end
   end

   assign capture_to_period = cap_per_reg;
   assign capture_to_duty = cap_dty_reg;
   assign counter_reset = crst_reg;

   // ****************************************
   // prescalers
   // ****************************************
   logic [PW-1:0] pre_cnt_reg [NSUB];
   logic [PW-1:0] pre_cnt_next [NSUB];
   logic [NSUB-1:0] tick_reg, tick_next;
   logic sub_on;

   // in dual mode either counter keeps the shared prescaler running
   always_comb begin
      tick_next = '0;
      sub_on = 1'b0;
      for (int s = 0; s < NSUB; s++) begin
         pre_cnt_next[s] = pre_cnt_reg[s];
         unique case (tpip_mode_t'(mode_f[s]))
            tpip_pkg::TPIP_PWM8: sub_on = cnt_run[2*s] | cnt_run[2*s+1];
            tpip_pkg::TPIP_PWM16, tpip_pkg::TPIP_CAPT: sub_on = cnt_run[2*s];
            default: sub_on = 1'b0;
         endcase

         if (tpip_mode_t'(mode_f[s]) == tpip_pkg::TPIP_LOWPWR) begin
            pre_cnt_next[s] = pre_cnt_reg[s]; // frozen while clocks are off
         end else if (!sub_on || crst_next[s]) begin
            pre_cnt_next[s] = '0;
         end else if (pre_cnt_reg[s] == pre_all[PW*s +: PW]) begin
            pre_cnt_next[s] = '0;
            tick_next[s] = 1'b1;
         end else begin
            pre_cnt_next[s] = pre_cnt_reg[s] + PW'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int s = 0; s < NSUB; s++) begin
            pre_cnt_reg[s] <= '0;
         end
         tick_reg <= '0;
      end else begin
         for (int s = 0; s < NSUB; s++) begin
            pre_cnt_reg[s] <= pre_cnt_next[s];
         end
         tick_reg <= tick_next;
      end
   end

   assign prescale_tick = tick_reg;

   // ****************************************
   // pwm pins
   // ****************************************
   logic [NPIN-1:0] pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next;
   logic pol, run_i, wrap_i, duty_i;
   int unsigned sidx, src;

   // duty beats wrap in one cycle, so a zero duty holds the idle level
   always_comb begin
      pin_out_next = pin_out_reg;
      pin_oe_next = '0;
      pol = 1'b0;
      run_i = 1'b0;
      wrap_i = 1'b0;
      duty_i = 1'b0;
      sidx = 0;
      src = 0;

      for (int i = 0; i < NPIN; i++) begin
         sidx = i / 2;
         // in 16-bit mode both pins follow the low counter
         src = (tpip_mode_t'(mode_f[sidx]) == tpip_pkg::TPIP_PWM16) ? 2 * sidx : i;
         pol = pin_ctl_all[FW*i + tpip_pkg::POL_BIT];
         run_i = cnt_run[src];
         wrap_i = cnt_wrap[src];
         duty_i = duty_match[src];

         if (tpip_mode_t'(mode_f[sidx]) == tpip_pkg::TPIP_PWM8 ||
             tpip_mode_t'(mode_f[sidx]) == tpip_pkg::TPIP_PWM16) begin
            pin_oe_next[i] = 1'b1;
            if (!run_i) begin
               pin_out_next[i] = pol;
            end else if (duty_i) begin
               pin_out_next[i] = pol;
            end else if (wrap_i) begin
               pin_out_next[i] = ~pol;
            end
         end else begin
            // capture and low-power leave the pin undriven
            pin_out_next[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pin_out_reg <= '0;
         pin_oe_reg <= '0;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   assign timer_pin_out = pin_out_reg;
   assign timer_pin_oe = pin_oe_reg;

   // ****************************************
   // interrupt sources and requests
   // ****************************************
   logic [NSUB-1:0] irq_req_reg, irq_req_next;
   logic irq_reg, irq_next;

   // low-power raises nothing; capture uses the registered strobes, a cycle late
   always_comb begin
      pend_set = '0;
      for (int s = 0; s < NSUB; s++) begin
         unique case (tpip_mode_t'(mode_f[s]))
            tpip_pkg::TPIP_PWM8: begin
               pend_set[PPS*s + tpip_pkg::SRC_A] = duty_match[2*s];
               pend_set[PPS*s + tpip_pkg::SRC_B] = period_match[2*s];
               pend_set[PPS*s + tpip_pkg::SRC_C] = duty_match[2*s+1];
               pend_set[PPS*s + tpip_pkg::SRC_D] = period_match[2*s+1];
            end
            tpip_pkg::TPIP_PWM16: begin
               pend_set[PPS*s + tpip_pkg::SRC_A] = duty_match[2*s];
               pend_set[PPS*s + tpip_pkg::SRC_B] = period_match[2*s];
            end
            tpip_pkg::TPIP_CAPT: begin
               pend_set[PPS*s + tpip_pkg::SRC_A] = cap_per_reg[s];
               pend_set[PPS*s + tpip_pkg::SRC_B] = cap_dty_reg[s];
               pend_set[PPS*s + tpip_pkg::SRC_C] = cnt_overflow[s];
            end
            default: ;
         endcase
      end
   end

   // requests use the next pending value so they rise with the pending bit
   always_comb begin
      for (int s = 0; s < NSUB; s++) begin
         irq_req_next[s] = |(irq_pending_next[PPS*s +: PPS] &
                             irq_enable_next[PPS*s +: PPS]);
      end
      irq_next = |irq_req_next;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irq_req_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         irq_req_reg <= irq_req_next;
         irq_reg <= irq_next;
      end
   end

   assign irq_req = irq_req_reg;
   assign irq = irq_reg;
endmodule

//--- tpip_pkg.sv
// What this block does
// - edge field picks capture edge and counter reset per the eight-entry code table.
// - edge field has no effect in either pwm mode.
// - a stopped counter parks its pwm pin at the polarity bit level.
// - polarity 0: pin high on counter 00h to 01h, low on duty match.
// - polarity 1: pin low on counter 00h to 01h, high on duty match.
// - polarity bit has no effect on pins in capture mode.
// - low pin register serves pins 1-4, high serves 5-8; nibble = edge[2:0], polarity[3].
// - sixteen enable bits, each gating its pending bit onto the subsystem request.
// - pending bits set on their events regardless of enable bits.
// - writing 1 clears a pending bit, 0 leaves it; only hardware sets.
// - all sixteen pending bits clear to zero on reset.
// - hardware never changes enable bits; only software writes do.
// - prescale pair a holds subsystems 1 and 2, pair b subsystems 3 and 4.
// - counter steps when prescale count matches compare; divides by compare plus one.
// - both pin control registers and enable register are read/write, reset zero.
// - one interrupt request per subsystem from its four gated pending bits.
// - pending sources per mode: pwm matches, or captures and overflow in capture mode.
// - in low-power mode a subsystem's pending bits cannot be cleared.
package tpip_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned NSUB = 4;
   localparam int unsigned NPIN = 8;
   localparam int unsigned PRE_W = 8;
   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_PIN_LOW = 8'h02;
   localparam logic [7:0] OFF_PIN_HIGH = 8'h04;
   localparam logic [7:0] OFF_IRQ_EN = 8'h06;
   localparam logic [7:0] OFF_IRQ_PEND = 8'h08;
   localparam logic [7:0] OFF_PRE_A = 8'h0a;
   localparam logic [7:0] OFF_PRE_B = 8'h18;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   // ****************************************
   // field layout
   // ****************************************
   localparam int unsigned PIN_FLD_W = 4;
   localparam int unsigned EDGE_LSB = 0;
   localparam int unsigned EDGE_W = 3;
   localparam int unsigned POL_BIT = 3;
   localparam int unsigned PEND_PER_SUB = 4;
   localparam int unsigned SRC_A = 0;
   localparam int unsigned SRC_B = 1;
   localparam int unsigned SRC_C = 2;
   localparam int unsigned SRC_D = 3;
   // edge field codes
   localparam logic [2:0] EDG_RISE = 3'h0;
   localparam logic [2:0] EDG_FALL = 3'h1;
   localparam logic [2:0] EDG_RISE_RST = 3'h2;
   localparam logic [2:0] EDG_FALL_RST = 3'h3;
   localparam logic [2:0] EDG_BOTH = 3'h4;
   localparam logic [2:0] EDG_BOTH_RRST = 3'h5;
   localparam logic [2:0] EDG_BOTH_FRST = 3'h6;
   localparam logic [2:0] EDG_BOTH_BRST = 3'h7;
   typedef enum logic [1:0] {
      TPIP_LOWPWR = 2'h0,
      TPIP_PWM8 = 2'h1,
      TPIP_PWM16 = 2'h2,
      TPIP_CAPT = 2'h3
   } tpip_mode_t;
endpackage

//--- tpip_ctl_checker.sv
`timescale 1ns/10ps
module tpip_ctl_checker #(
   parameter int unsigned NSUB = tpip_pkg::NSUB,
   parameter int unsigned NPIN = tpip_pkg::NPIN
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [tpip_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [tpip_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [tpip_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [2*NSUB-1:0] sub_mode,
   input wire logic [NPIN-1:0] cnt_run,
   input wire logic [NPIN-1:0] cnt_wrap,
   input wire logic [NPIN-1:0] duty_match,
   input wire logic [NPIN-1:0] timer_pin_out,
   input wire logic [NPIN-1:0] timer_pin_oe,
   input wire logic [NSUB-1:0] capture_to_period,
   input wire logic [NSUB-1:0] capture_to_duty,
   input wire logic [NSUB-1:0] counter_reset,
   input wire logic [NSUB-1:0] irq_req,
   input wire logic irq
);
   // ********
   // shadow of pin 1 polarity, taken from the bus
   // ********
   logic pol_reg;
   logic pol_next;
   always_comb begin
      pol_next = pol_reg;
      if (reg_wr && reg_addr == tpip_pkg::OFF_PIN_LOW) begin
         pol_next = reg_wdata[3];
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pol_reg <= 1'b0;
      end else begin
         pol_reg <= pol_next;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside read answer");
   a_irq_or: assert property (irq == (|irq_req))
      else $error("irq differs from or of requests");
   a_irq_mask: assert property (reg_wr && reg_addr == tpip_pkg::OFF_IRQ_EN &&
      reg_wdata == 16'h0000 |=> ##1 irq_req == '0)
      else $error("request stays with all enables off");
   a_stop_pol: assert property (sub_mode[1:0] == 2'h1 && !cnt_run[0]
      |=> timer_pin_out[0] == $past(pol_reg))
      else $error("stopped pin not at polarity");
   a_wrap_level: assert property (sub_mode[1:0] == 2'h1 && cnt_run[0] && cnt_wrap[0]
      && !duty_match[0] |=> timer_pin_out[0] == !$past(pol_reg))
      else $error("wrong level after counter wrap");
   a_duty_level: assert property (sub_mode[1:0] == 2'h1 && duty_match[0]
      |=> timer_pin_out[0] == $past(pol_reg))
      else $error("wrong level after duty match");
   a_capt_pins: assert property (sub_mode[1:0] == 2'h3
      |=> timer_pin_oe[1:0] == 2'h0 && timer_pin_out[1:0] == 2'h0)
      else $error("pin driven in capture mode");
   a_pwm_oe: assert property (sub_mode[1:0] == 2'h1 |=> timer_pin_oe[1:0] == 2'h3)
      else $error("pwm pins not driven");
   a_edge_gate: assert property ((sub_mode[1:0] != 2'h3) [*4] |=>
      !capture_to_period[0] && !capture_to_duty[0] && !counter_reset[0])
      else $error("capture or reset outside capture mode");
endmodule
bind tpip_ctl tpip_ctl_checker #(.NSUB(NSUB), .NPIN(NPIN)) tpip_ctl_checker_i (
   .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sub_mode, .cnt_run,
   .cnt_wrap, .duty_match, .timer_pin_out, .timer_pin_oe, .capture_to_period,
   .capture_to_duty, .counter_reset, .irq_req, .irq);

//--- tpip_pin_model.sv
`timescale 1ns/10ps
module tpip_pin_model (
   input wire logic [7:0] ext_lvl,
   input wire logic [7:0] drv_out,
   input wire logic [7:0] drv_oe,
   output logic [7:0] pin_lvl
);
   // ********
   // pin level resolution
   // ********
   // a driven pin reads back its own level, so pwm output edges also reach the synchroniser and edge detect
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_lvl[i] = drv_oe[i] ? drv_out[i] : ext_lvl[i];
      end
   end
endmodule

//--- tb_timer_pin_irq_prescale_ctl.sv
`timescale 1ns/10ps
module tb_timer_pin_irq_prescale_ctl;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] sub_mode = 8'h00, cnt_run = 8'h00, cnt_wrap = 8'h00, ext_lvl = 8'h00;
   logic [7:0] duty_match = 8'h00, period_match = 8'h00;
   logic [3:0] cnt_overflow = 4'h0;
   logic [15:0] reg_rdata;
   logic [7:0] timer_pin_in, timer_pin_out, timer_pin_oe;
   logic [3:0] prescale_tick, capture_to_period, capture_to_duty, counter_reset, irq_req;
   logic irq, cx, rx;
   logic [2:0] code;
   logic [39:0] regs [8];
   logic [10:0] evts [9];
   logic [25:0] pres [4];
   int fails = 0;
   int checked = 0;
   int ncap = 0, ndut = 0, nres = 0, b0, b1, b2, n;
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      ncap <= ncap + capture_to_period[0];
      ndut <= ndut + capture_to_duty[0];
      nres <= nres + counter_reset[0];
   end
   tpip_ctl tpip_ctl_i (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .sub_mode, .cnt_run, .cnt_wrap, .duty_match, .period_match, .cnt_overflow,
      .timer_pin_in, .timer_pin_out, .timer_pin_oe, .prescale_tick, .capture_to_period,
      .capture_to_duty, .counter_reset, .irq_req, .irq);
   tpip_pin_model tpip_pin_model_i (.ext_lvl(ext_lvl), .drv_out(timer_pin_out),
      .drv_oe(timer_pin_oe), .pin_lvl(timer_pin_in));
   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         $display("Error at %0t: %s", $time, msg);
         fails++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata === e, "read data");
   endtask
   task automatic st(input logic [7:0] m, input logic [7:0] r);
      @(posedge mclk);
      sub_mode <= m;
      cnt_run <= r;
   endtask
   task automatic pl(input logic [7:0] w, d, pm, input logic [3:0] o);
      @(posedge mclk);
      cnt_wrap <= w;
      duty_match <= d;
      period_match <= pm;
      cnt_overflow <= o;
      @(posedge mclk);
      {cnt_wrap, duty_match, period_match, cnt_overflow} <= 28'h0000000;
      #1;
   endtask
   task automatic meas(input int s, input int e);
      n = 0;
      // let the new compare reach the counter before looking for a tick
      repeat (2) @(posedge mclk);
      #1;
      // the first tick may come late while the count runs past a lowered compare
      while (prescale_tick[s] !== 1'b1 && n < 600) begin
         @(posedge mclk);
         #1;
         n++;
      end
      @(posedge mclk);
      #1;
      n = 1;
      while (prescale_tick[s] !== 1'b1 && n < 600) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 600) begin
         fails++;
         print_verdict();
      end
      chk(n == e, "tick spacing");
   endtask
   initial begin
      regs = '{{8'h02, 16'hffff, 16'hffff}, {8'h04, 16'ha5a5, 16'ha5a5},
         {8'h06, 16'h0f0f, 16'h0f0f}, {8'h0a, 16'h1234, 16'h1234}, {8'h18, 16'hff01, 16'hff01},
         {8'h08, 16'hffff, 16'h0000}, {8'h0c, 16'hffff, 16'h0000}, {8'h00, 16'h5555, 16'h0000}};
      evts = '{{2'h1, 2'h1, 2'h0, 1'h0, 4'h1}, {2'h1, 2'h0, 2'h1, 1'h0, 4'h2},
         {2'h1, 2'h2, 2'h0, 1'h0, 4'h4}, {2'h1, 2'h0, 2'h2, 1'h0, 4'h8},
         {2'h2, 2'h1, 2'h0, 1'h0, 4'h1}, {2'h2, 2'h0, 2'h1, 1'h0, 4'h2},
         {2'h2, 2'h2, 2'h2, 1'h0, 4'h0}, {2'h3, 2'h0, 2'h0, 1'h1, 4'h4},
         {2'h0, 2'h3, 2'h3, 1'h1, 4'h0}};
      pres = '{{8'h0a, 16'h0000, 2'h0}, {8'h0a, 16'h0300, 2'h1}, {8'h18, 16'h0005, 2'h2},
         {8'h18, 16'hff00, 2'h3}};
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rdc(regs[i][39:32], 16'h0000);
      end
      for (int i = 0; i < 8; i++) begin
         wr(regs[i][39:32], regs[i][31:16]);
         rdc(regs[i][39:32], regs[i][15:0]);
      end
      $display("register table done");
      wr(8'h02, 16'h0000);
      wr(8'h06, 16'h0000);
      for (int i = 0; i < 9; i++) begin
         st({6'h00, evts[i][10:9]}, 8'h03);
         pl(8'h00, {6'h00, evts[i][8:7]}, {6'h00, evts[i][6:5]}, {3'h0, evts[i][4]});
         repeat (2) @(posedge mclk);
         rdc(8'h08, {12'h000, evts[i][3:0]});
         wr(8'h08, 16'hffff);
      end
      $display("event sources done");
      st(8'h03, 8'h03);
      for (int c = 0; c < 8; c++) begin
         code = c[2:0];
         wr(8'h02, {8'h00, 1'b0, code, 1'b0, code});
         for (int e = 0; e < 2; e++) begin
            cx = (e == 0) ? (code != 3'h1 && code != 3'h3) :
               (code == 3'h1 || code == 3'h3 || code[2]);
            rx = (e == 0) ? (code == 3'h2 || code == 3'h5 || code == 3'h7) :
               (code == 3'h3 || code >= 3'h6);
            b0 = ncap;
            b1 = ndut;
            b2 = nres;
            @(posedge mclk);
            ext_lvl <= {6'h00, {2{e == 0}}};
            repeat (8) @(posedge mclk);
            #1;
            chk(ncap - b0 == int'(cx), "period capture count");
            chk(ndut - b1 == int'(cx), "duty capture count");
            chk(nres - b2 == int'(rx), "counter reset count");
            rdc(8'h08, cx ? 16'h0003 : 16'h0000);
            wr(8'h08, 16'hffff);
         end
      end
      $display("capture codes done");
      for (int p = 0; p < 2; p++) begin
         st(8'h01, 8'h01);
         wr(8'h02, {12'h000, p[0], 3'h0});
         pl(8'h01, 8'h00, 8'h00, 4'h0);
         chk(timer_pin_out[0] === !p[0], "level after wrap");
         chk(timer_pin_oe[0] === 1'b1, "pwm pin driven");
         pl(8'h00, 8'h01, 8'h00, 4'h0);
         chk(timer_pin_out[0] === p[0], "level after duty");
         pl(8'h01, 8'h00, 8'h00, 4'h0);
         st(8'h01, 8'h00);
         @(posedge mclk);
         #1;
         chk(timer_pin_out[0] === p[0], "stopped level");
      end
      $display("pwm levels done");
      st(8'h01, 8'h01);
      wr(8'h06, 16'h0000);
      pl(8'h00, 8'h01, 8'h00, 4'h0);
      rdc(8'h08, 16'h0001);
      chk(irq === 1'b0 && irq_req === 4'h0, "masked request");
      wr(8'h06, 16'h0001);
      repeat (2) @(posedge mclk);
      chk(irq === 1'b1 && irq_req === 4'h1, "enabled request");
      wr(8'h08, 16'h0000);
      rdc(8'h08, 16'h0001);
      rdc(8'h06, 16'h0001);
      st(8'h00, 8'h01);
      wr(8'h08, 16'hffff);
      rdc(8'h08, 16'h0001);
      st(8'h01, 8'h01);
      wr(8'h08, 16'h0001);
      rdc(8'h08, 16'h0000);
      chk(irq === 1'b0, "request after clear");
      $display("interrupt path done");
      st(8'h55, 8'hff);
      for (int i = 0; i < 4; i++) begin
         wr(pres[i][25:18], pres[i][17:2]);
         meas(pres[i][1:0], (pres[i][0] ? pres[i][17:10] : pres[i][9:2]) + 1);
      end
      $display("prescaler done");
      pl(8'h00, 8'h01, 8'h00, 4'h0);
      rdc(8'h08, 16'h0001);
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rdc(8'h08, 16'h0000);
      rdc(8'h06, 16'h0000);
      $display("second reset done");
      print_verdict();
   end
endmodule
